// ==== src/stpm_pin_mux.sv ====
`timescale 1ns/1ns
module stpm_pin_mux
  import stpm_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [7:0]          port0_in,
  input  wire logic [7:0]          port1_in,
  input  wire logic [7:0]          port3_in,
  output stpm_pad_type             port0_pad,
  output stpm_pad_type             port1_pad,
  output stpm_pad_type             port3_pad,
  input  wire stpm_periph_out_type periph_out,
  output stpm_periph_in_type       periph_in
);

  logic [7:0]          regs_q [NUM_REGS];
  logic                aw_held_q;
  logic                w_held_q;
  logic [4:0]          aw_idx_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                awready_q;
  logic                wready_q;
  logic                arready_q;
  logic [23:0]         sync1_q;
  logic [23:0]         sync2_q;
  logic [23:0]         sync3_q;
  logic [23:0]         filt_q;
  logic [23:0]         filt_d;
  logic [BUZ_W-1:0]    buz_cnt_q;
  logic                buz_q;
  stpm_pad_type        pad0_q;
  stpm_pad_type        pad1_q;
  stpm_pad_type        pad3_q;
  stpm_pad_type        pad0_d;
  stpm_pad_type        pad1_d;
  stpm_pad_type        pad3_d;
  stpm_periph_in_type  pin_q;
  stpm_periph_in_type  pin_d;

  // bus decode
  wire        aw_take    = s_axi_awvalid && !aw_held_q && !bvalid_q;
  wire        w_take     = s_axi_wvalid && !w_held_q && !bvalid_q;
  wire        wr_fire    = aw_held_q && w_held_q && !bvalid_q;
  wire        wr_mapped  = aw_idx_q < 5'(NUM_REGS);
  wire [4:0]  ar_idx     = s_axi_araddr[6:2];
  wire        ar_hi_zero = s_axi_araddr[31:7] == 25'h000_0000;
  wire        ar_take    = s_axi_arvalid && !rvalid_q;
  wire        ar_reg     = ar_hi_zero && ar_idx < 5'(NUM_REGS);
  wire        ar_stat    = ar_hi_zero && ar_idx == RI_STATUS;
  wire [7:0]  ar_val     = ar_reg ? regs_q[ar_idx[3:0]] : 8'h00;
  wire [31:0] stat_val   = {8'h00, filt_q[23:16], filt_q[15:8], filt_q[7:0]};
  wire [31:0] rd_val     = ar_stat ? stat_val : {24'h00_0000, ar_val};
  wire        rd_ok      = ar_reg || ar_stat;
  // next state of the handshake flops, so the readies can be registered too
  wire        aw_held_d  = !wr_fire && (aw_take || aw_held_q);
  wire        w_held_d   = !wr_fire && (w_take || w_held_q);
  wire        bvalid_d   = wr_fire || (bvalid_q && !s_axi_bready);
  wire        rvalid_d   = ar_take || (rvalid_q && !s_axi_rready);

  // pull-ups on port 0 and 3 follow software even on driven pins
  // pin view of the registers
  wire [7:0]  dir0 = regs_q[RI_P0_DIR[3:0]];
  wire [7:0]  dir1 = regs_q[RI_P1_DIR[3:0]];
  wire [7:0]  dir3 = regs_q[RI_P3_DIR[3:0]];
  wire [7:0]  omd1 = regs_q[RI_P1_OMD[3:0]];
  wire [7:0]  carr = regs_q[RI_CARR[3:0]];
  wire [7:0]  dly  = regs_q[RI_DLY[3:0]];
  wire [2:0]  buz_sel  = dly[DLY_FS_LO +: 3];
  wire [BUZ_W-1:0] buz_mask = BUZ_W'((1 << (BUZ_BASE + int'(buz_sel))) - 1);
  wire        buz_tick = (buz_cnt_q & buz_mask) == BUZ_CNT_RESET;

  // a change counts once the second and third stage agree
  assign filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));

  // readies sit in flops so the bus sees no path from logic to its pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      awready_q <= !aw_held_d && !bvalid_d;
      wready_q  <= !w_held_d && !bvalid_d;
      arready_q <= !rvalid_d;
    end
  end

  always_comb begin
    logic [7:0] dir;
    logic [7:0] filt;
    logic [7:0] md;
    logic       v;
    int         b;
    int         tb;
    stpm_pad_type pd [2];
    dir  = 8'h00;
    filt = 8'h00;
    md   = 8'h00;
    v    = 1'b0;
    b    = 0;
    tb   = 0;
    pd[0] = '{o: regs_q[RI_P0_OUT[3:0]], oe: dir0, pu: regs_q[RI_P0_PU[3:0]]};
    pd[1] = '{o: regs_q[RI_P3_OUT[3:0]], oe: dir3, pu: regs_q[RI_P3_PU[3:0]]};
    pin_d = '{ser_rx: 4'hf, ser_clk: 4'hf, tmr_event: 6'h00};
    // channels 0/2 sit on port 0, 1/3 on port 3; channels 0/1 use bits 0-2 of their port, 2/3 bits 3-5
    for (int c = 0; c < 4; c++) begin
      dir  = (c % 2 == 0) ? dir0 : dir3;
      filt = (c % 2 == 0) ? filt_q[7:0] : filt_q[23:16];
      md   = regs_q[RI_SC_MD1[3:0] + 4'(c)];
      b    = (c / 2) * SER_HI_B;
      if (md[MD_TX] && dir[b]) begin
        v = periph_out.ser_tx[c];
        pd[c % 2].o[b]  = md[MD_TXOD] ? 1'b0 : v;
        pd[c % 2].oe[b] = md[MD_TXOD] ? !v : 1'b1;
      end
      if (md[MD_RX] && !dir[b + 1]) begin
        pin_d.ser_rx[c] = filt[b + 1];
      end
      if (md[MD_CLK]) begin
        if (dir[b + 2]) begin
          v = periph_out.ser_clk[c];
          pd[c % 2].o[b + 2]  = md[MD_CKOD] ? 1'b0 : v;
          pd[c % 2].oe[b + 2] = md[MD_CKOD] ? !v : 1'b1;
        end else begin
          pin_d.ser_clk[c] = filt[b + 2];
        end
      end
    end
    if (dly[DLY_BZ_EN] && dir0[BUZ_BIT]) begin
      pd[0].o[BUZ_BIT] = buz_q;
    end
    pad0_d = pd[0];
    pad3_d = pd[1];
    // unselected timer pins keep plain port behaviour
    pad1_d = '{o: regs_q[RI_P1_OUT[3:0]], oe: dir1, pu: regs_q[RI_P1_PU[3:0]] & ~dir1};
    for (int t = 0; t < 6; t++) begin
      tb = int'(TMR_BIT[t]);
      if (!dir1[tb]) begin
        pin_d.tmr_event[t] = filt_q[8 + tb];
      end
      if (omd1[tb] && dir1[tb]) begin
        pad1_d.o[tb] = periph_out.tmr_out[t];
      end
    end
    if (omd1[CAR_BIT] && dir1[CAR_BIT] && carr[CARR_EN]) begin
      pad1_d.o[CAR_BIT] = periph_out.carrier;
    end
  end

  // three stages so a pin caught mid-change never reaches the selectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 24'h00_0000;
      sync2_q <= 24'h00_0000;
      sync3_q <= 24'h00_0000;
      filt_q  <= 24'h00_0000;
    end else begin
      sync1_q <= {port3_in, port1_in, port0_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  // buzzer: free divider, tick pulse toggles the tone; silent while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buz_cnt_q <= BUZ_CNT_RESET;
      buz_q     <= 1'b0;
    end else begin
      buz_cnt_q <= buz_cnt_q + 1'b1;
      if (!dly[DLY_BZ_EN]) begin
        buz_q <= 1'b0;
      end else if (buz_tick) begin
        buz_q <= !buz_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad0_q <= '0;
      pad1_q <= '0;
      pad3_q <= '0;
      pin_q  <= '{ser_rx: 4'hf, ser_clk: 4'hf, tmr_event: 6'h00};
    end else begin
      pad0_q <= pad0_d;
      pad1_q <= pad1_d;
      pad3_q <= pad3_d;
      pin_q  <= pin_d;
    end
  end

  // write path: address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 5'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= (s_axi_awaddr[31:7] == 25'h000_0000) ? s_axi_awaddr[6:2] : 5'h1f;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (wr_fire && wr_mapped && wstrb_q[0]) begin
      regs_q[aw_idx_q[3:0]] <= wdata_q[7:0];
    end
  end

  // read path: one read under way at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign port0_pad     = pad0_q;
  assign port1_pad     = pad1_q;
  assign port3_pad     = pad3_q;
  assign periph_in     = pin_q;

endmodule

// ==== inc/stpm_pkg.sv ====
package stpm_pkg;

  // register indices; byte address is four times the index
  localparam logic [4:0] RI_P0_OUT  = 5'h00;
  localparam logic [4:0] RI_P0_DIR  = 5'h01;
  localparam logic [4:0] RI_P0_PU   = 5'h02;
  localparam logic [4:0] RI_P1_OUT  = 5'h03;
  localparam logic [4:0] RI_P1_DIR  = 5'h04;
  localparam logic [4:0] RI_P1_PU   = 5'h05;
  localparam logic [4:0] RI_P1_OMD  = 5'h06;
  localparam logic [4:0] RI_P3_OUT  = 5'h07;
  localparam logic [4:0] RI_P3_DIR  = 5'h08;
  localparam logic [4:0] RI_P3_PU   = 5'h09;
  localparam logic [4:0] RI_SC_MD1  = 5'h0a;
  localparam logic [4:0] RI_CARR    = 5'h0e;
  localparam logic [4:0] RI_DLY     = 5'h0f;
  localparam logic [4:0] RI_STATUS  = 5'h10;
  localparam int         NUM_REGS   = 16;

  localparam logic [7:0] REG_RESET  = 8'h00;

  // serial_channel_mode1 fields
  localparam int MD_TX   = 0;
  localparam int MD_RX   = 1;
  localparam int MD_CLK  = 2;
  localparam int MD_TXOD = 3;
  localparam int MD_CKOD = 4;

  // carrier_output_control and delay_control fields
  localparam int CARR_EN   = 0;
  localparam int DLY_BZ_EN = 0;
  localparam int DLY_FS_LO = 1;

  // pin positions
  localparam int BUZ_BIT  = 6;
  localparam int CAR_BIT  = 0;
  localparam int SER_HI_B = 3;
  localparam logic [2:0] TMR_BIT [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd6, 3'd4};

  // buzzer divider: period of the half wave is 2^(BUZ_BASE+sel) cycles
  localparam int BUZ_BASE = 4;
  localparam int BUZ_W    = 12;
  localparam logic [BUZ_W-1:0] BUZ_CNT_RESET = 12'h000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } stpm_pad_type;

  typedef struct packed {
    logic [3:0] ser_tx;
    logic [3:0] ser_clk;
    logic [5:0] tmr_out;
    logic       carrier;
  } stpm_periph_out_type;

  typedef struct packed {
    logic [3:0] ser_rx;
    logic [3:0] ser_clk;
    logic [5:0] tmr_event;
  } stpm_periph_in_type;

endpackage

// ==== test/stpm_pin_mux_properties.sv ====
`timescale 1ns/1ns
module stpm_pin_mux_chk
  import stpm_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire stpm_pad_type       port0_pad,
  input wire stpm_pad_type       port1_pad,
  input wire stpm_pad_type       port3_pad,
  input wire stpm_periph_in_type periph_in
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer off time");
  // one cycle of skew between pad and input selection is tolerated
  a_rx_input_only: assert property (!periph_in.ser_rx[0] && !$past(periph_in.ser_rx[0])
    |-> !(port0_pad.oe[1] && $past(port0_pad.oe[1]))) else $error("rx taken from driven pin");
  a_uart_rx_input: assert property (!periph_in.ser_rx[1] && !$past(periph_in.ser_rx[1])
    |-> !(port3_pad.oe[1] && $past(port3_pad.oe[1]))) else $error("uart rx taken from driven pin");
  a_clk_in_only: assert property (!periph_in.ser_clk[0] && !$past(periph_in.ser_clk[0])
    |-> !(port0_pad.oe[2] && $past(port0_pad.oe[2]))) else $error("clock taken from driven pin");
  a_event_input: assert property (periph_in.tmr_event[0] && $past(periph_in.tmr_event[0])
    |-> !(port1_pad.oe[0] && $past(port1_pad.oe[0]))) else $error("event from driven pin");
  a_wide_event_in: assert property (periph_in.tmr_event[5] && $past(periph_in.tmr_event[5])
    |-> !(port1_pad.oe[4] && $past(port1_pad.oe[4]))) else $error("wide event from driven pin");
  a_timer_pullup: assert property ((port1_pad.pu & port1_pad.oe & 8'h5f) == 8'h00)
    else $error("pull-up on driven timer pin");
endmodule
bind stpm_pin_mux stpm_pin_mux_chk u_stpm_pin_mux_chk (.*);

// ==== test/stpm_pin_partner.sv ====
`timescale 1ns/1ns
module stpm_pin_partner
  import stpm_pkg::*;
(
  input  wire logic         aclk,
  input  wire stpm_pad_type port0_pad,
  input  wire stpm_pad_type port1_pad,
  input  wire stpm_pad_type port3_pad,
  input  wire logic [23:0]  drv_en,
  input  wire logic [23:0]  drv,
  output wire logic [7:0]   port0_in,
  output wire logic [7:0]   port1_in,
  output wire logic [7:0]   port3_in
);
  // released pins without pull-up flip each cycle so a stale level never reads as data
  logic [7:0] flt_q = 8'h55;
  always @(posedge aclk) flt_q <= ~flt_q;
  function automatic logic [7:0] lvl(stpm_pad_type p, logic [7:0] e, logic [7:0] d, logic [7:0] f);
    return (p.oe & p.o) | (~p.oe & e & d) | (~p.oe & ~e & (p.pu | f));
  endfunction
  assign port0_in = lvl(port0_pad, drv_en[7:0], drv[7:0], flt_q);
  assign port1_in = lvl(port1_pad, drv_en[15:8], drv[15:8], flt_q);
  assign port3_in = lvl(port3_pad, drv_en[23:16], drv[23:16], flt_q);
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import stpm_pkg::*;
  logic                aclk = 0;
  logic                aresetn = 0;
  logic [31:0]         s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic                s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, b;
  logic [1:0]          s_axi_bresp, s_axi_rresp, rs_q;
  logic [31:0]         s_axi_rdata, rd_q;
  wire logic [7:0]     port0_in, port1_in, port3_in;
  stpm_pad_type        port0_pad, port1_pad, port3_pad;
  stpm_periph_out_type periph_out = 0;
  stpm_periph_in_type  periph_in;
  logic [23:0]         drv_en = 0, drv = 0;
  int                  error_cnt = 0, num_checks = 0;
  always #5 aclk = ~aclk;
  stpm_pin_mux u_stpm_pin_mux (.*);
  stpm_pin_partner u_stpm_pin_partner (.*);
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // ready and valid are sampled mid-cycle, so the value seen is the one the edge takes
  task automatic xfer(input logic wr, input logic [4:0] ri, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw, done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= {25'h0, ri, 2'b00};
    s_axi_araddr <= {25'h0, ri, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (int n = 0; n < 100 && !done; n++) begin
      @(negedge aclk);
      ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      tw = s_axi_wvalid && s_axi_wready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rd_q = s_axi_rdata;
      rs_q = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) begin
        s_axi_awvalid <= 0;
        s_axi_arvalid <= 0;
      end
      if (tw) s_axi_wvalid <= 0;
      if (done) begin
        s_axi_bready <= 0;
        s_axi_rready <= 0;
      end
    end
    if (!done) begin
      error_cnt++;
      results();
    end else begin
      chk("resp", 32'(rs_q), 32'(er));
    end
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    wt(1);
    chk("pads", 32'(port0_pad | port1_pad | port3_pad), 32'h0);
    $display("reset test done");
    xfer(1, RI_P1_PU, 8'hff);
    xfer(1, RI_P1_DIR, 8'h0f);
    xfer(1, RI_P1_OUT, 8'h0a);
    wt(2);
    chk("p1 gpio", 32'(port1_pad), 32'h000a_0ff0);
    xfer(1, RI_P1_OMD, 8'h5f);
    periph_out.tmr_out <= 6'h2a;
    xfer(1, RI_P1_DIR, 8'h5f);
    wt(2);
    chk("p1 timer", 32'(port1_pad), 32'h001a_5fa0);
    xfer(1, RI_CARR, 8'h01);
    periph_out.carrier <= 1;
    wt(2);
    chk("carrier", 32'(port1_pad.o), 32'h0000_001b);
    xfer(1, RI_P1_OMD, 8'h5e);
    wt(2);
    chk("no carrier", 32'(port1_pad.o), 32'h0000_001a);
    xfer(1, RI_P1_DIR, 8'h00);
    drv_en[15:8] <= 8'hff;
    drv[15:8] <= 8'h51;
    wt(8);
    chk("events", 32'(periph_in.tmr_event), 32'h0000_0031);
    $display("timer test done");
    xfer(1, RI_SC_MD1, 8'h07);
    periph_out.ser_tx <= 4'h1;
    periph_out.ser_clk <= 4'hf;
    xfer(1, RI_P0_DIR, 8'h01);
    drv_en[7:0] <= 8'h06;
    wt(8);
    chk("ser pins", 32'({port0_pad.oe[2:0], port0_pad.o[2:0]}), 32'h0000_0009);
    chk("ser in", 32'({periph_in.ser_rx, periph_in.ser_clk}), 32'h0000_00ee);
    xfer(1, RI_SC_MD1, 8'h0f);
    xfer(1, RI_P0_DIR, 8'h05);
    wt(8);
    chk("od high", 32'({port0_pad.oe[2:0], port0_pad.o[2:0]}), 32'h0000_0024);
    chk("clk out", 32'({periph_in.ser_rx, periph_in.ser_clk}), 32'h0000_00ef);
    @(posedge aclk);
    periph_out.ser_tx <= 4'h2;
    wt(2);
    chk("od low", 32'({port0_pad.oe[2:0], port0_pad.o[2:0]}), 32'h0000_002c);
    xfer(1, RI_SC_MD1, 8'h1f);
    wt(2);
    chk("clk od high", 32'({port0_pad.oe[2:0], port0_pad.o[2:0]}), 32'h0000_0008);
    @(posedge aclk);
    periph_out.ser_clk <= 4'he;
    wt(2);
    chk("clk od low", 32'({port0_pad.oe[2:0], port0_pad.o[2:0]}), 32'h0000_0028);
    xfer(1, RI_SC_MD1 + 5'h01, 8'h03);
    xfer(1, RI_P3_DIR, 8'h01);
    drv_en[23:16] <= 8'h02;
    wt(8);
    chk("uart pins", 32'({port3_pad.oe[1:0], port3_pad.o[1:0]}), 32'h0000_0005);
    chk("uart rx", 32'(periph_in.ser_rx), 32'h0000_000c);
    $display("serial test done");
    xfer(1, RI_P0_DIR, 8'h40);
    for (int s = 0; s < 3; s++) begin
      xfer(1, RI_DLY, 8'(2 * s + 1));
      wt(2);
      b = port0_pad.o[6];
      repeat (1 << (4 + s)) @(negedge aclk);
      chk("buzzer", 32'({port0_pad.oe[6], port0_pad.o[6]}), 32'({1'b1, !b}));
    end
    $display("buzzer test done");
    xfer(1, 5'h11, 8'h01, RESP_SLVERR);
    xfer(0, 5'h11, 8'h00, RESP_SLVERR);
    chk("unmapped", rd_q, 32'h0);
    s_axi_wstrb <= 4'he;
    xfer(1, RI_P3_DIR, 8'hff);
    s_axi_wstrb <= 4'hf;
    xfer(0, RI_P3_DIR, 8'h00);
    chk("readback", rd_q, 32'h0000_0001);
    xfer(0, RI_STATUS, 8'h00);
    chk("status", 32'(rd_q[15:8]), 32'h0000_0051);
    $display("bus test done");
    results();
  end
endmodule
